// file: hdl/eefac_byte_array.sv
`timescale 1ns/100ps
`include "eefac_consts.svh"

// nonvolatile contents: no reset on purpose
module eefac_byte_array (
    input wire logic clock,
    input wire logic erase_en,
    input wire logic prog_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] mem [0:255];

    always_ff @(posedge clock)
    begin
        if (erase_en)
        begin
            mem[wr_addr] <= `EEFAC_ERASED_BYTE;
        end
        else if (prog_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];

endmodule

// file: hdl/eefac_ctrl.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "eefac_consts.svh"

module eefac_ctrl (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic external_reset_pin,
    input wire logic watchdog_reset_source,
    input wire logic brownout_reset_source,
    output logic [12:0] prog_addr,
    input wire logic [13:0] prog_word,
    output logic write_done_irq_flag,
    output logic write_busy
);

    logic [7:0] nv_data_low, next_data_low;
    logic [5:0] program_word_high, next_word_high;
    logic [7:0] nv_address_low, next_address_low;
    logic [4:0] program_address_high, next_address_high;
    logic memory_select, next_memory_select;
    logic write_abort_flag, next_abort_flag;
    logic write_permit, next_write_permit;
    logic write_start, next_write_start;
    logic read_start, next_read_start;
    logic done_flag, next_done_flag;
    logic [1:0] key_stage, next_key_stage;
    eefac_pkg::eefac_wstate_t wstate, next_wstate;
    eefac_pkg::eefac_pread_t pread, next_pread;
    logic [15:0] wcount, next_wcount;
    logic [7:0] latch_addr, next_latch_addr;
    logic [7:0] latch_data, next_latch_data;
    logic [7:0] next_rdata;
    logic [2:0] rst_raw, sync1, sync2, sync3, rst_level, next_rst_level;
    logic dev_rst;
    logic bus_wr, bus_rd;
    logic erase_en, prog_en;
    logic [7:0] rd_byte;
    logic [7:0] ctrl_view;

    // three-stage synchronisers; a level change counts once stages two and three agree
    assign rst_raw = {brownout_reset_source, watchdog_reset_source, external_reset_pin};
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_rst_sync
            assign next_rst_level[g] = (sync2[g] == sync3[g]) ? sync3[g] : rst_level[g];
        end
    endgenerate
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            rst_level <= 3'h0;
        end
        else
        begin
            sync1 <= rst_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            rst_level <= next_rst_level;
        end
    end

    assign dev_rst = |rst_level;
    // the cycle after the first one following a program read start belongs to the flash
    assign bus_wr = reg_wr && (pread != eefac_pkg::EEFAC_PR_SECOND);
    assign bus_rd = reg_rd && (pread != eefac_pkg::EEFAC_PR_SECOND);

    assign erase_en = (wstate == eefac_pkg::EEFAC_ERASE) && (wcount == 16'h0001) && !dev_rst;
    assign prog_en = (wstate == eefac_pkg::EEFAC_PROGRAM) && (wcount == 16'h0001) && !dev_rst;
    eefac_byte_array u_array (
        .clock(clock),
        .erase_en(erase_en),
        .prog_en(prog_en),
        .wr_addr(latch_addr),
        .wr_data(latch_data),
        .rd_addr(nv_address_low),
        .rd_data(rd_byte)
    );

    assign ctrl_view = {memory_select, 3'b000, write_abort_flag, write_permit,
                        write_start, read_start};

    always_comb
    begin
        next_data_low = nv_data_low;
        next_word_high = program_word_high;
        next_address_low = nv_address_low;
        next_address_high = program_address_high;
        next_memory_select = memory_select;
        next_abort_flag = write_abort_flag;
        next_write_permit = write_permit;
        next_write_start = write_start;
        next_read_start = read_start;
        next_done_flag = done_flag;
        next_key_stage = key_stage;
        next_wstate = wstate;
        next_pread = pread;
        next_wcount = wcount;
        next_latch_addr = latch_addr;
        next_latch_data = latch_data;
        next_rdata = `EEFAC_BYTE_ZERO;

        // read answer, valid in the following cycle only
        if (bus_rd)
        begin
            unique case (reg_addr)
                `EEFAC_OFS_DATA_LOW: next_rdata = nv_data_low;
                `EEFAC_OFS_DATA_HIGH: next_rdata = {2'b00, program_word_high};
                `EEFAC_OFS_ADDR_LOW: next_rdata = nv_address_low;
                `EEFAC_OFS_ADDR_HIGH: next_rdata = {3'b000, program_address_high};
                `EEFAC_OFS_CONTROL: next_rdata = ctrl_view;
                `EEFAC_OFS_STATUS: next_rdata = {7'h00, done_flag};
                default: next_rdata = `EEFAC_BYTE_ZERO;
            endcase
        end

        // program read: capture the word at the end of the ignored cycle
        unique case (pread)
            eefac_pkg::EEFAC_PR_FIRST: next_pread = eefac_pkg::EEFAC_PR_SECOND;
            eefac_pkg::EEFAC_PR_SECOND:
            begin
                next_pread = eefac_pkg::EEFAC_PR_NONE;
                next_data_low = prog_word[7:0];
                next_word_high = prog_word[13:8];
                next_read_start = 1'b0;
            end
            default: next_pread = eefac_pkg::EEFAC_PR_NONE;
        endcase

        // self-timed erase then program; the latched copy keeps the write immune to later edits
        unique case (wstate)
            eefac_pkg::EEFAC_ERASE:
            begin
                next_wcount = wcount - 16'h0001;
                if (wcount == 16'h0001)
                begin
                    next_wstate = eefac_pkg::EEFAC_PROGRAM;
                    next_wcount = 16'(`EEFAC_PROG_CYCLES);
                end
            end
            eefac_pkg::EEFAC_PROGRAM:
            begin
                next_wcount = wcount - 16'h0001;
                if (wcount == 16'h0001)
                begin
                    next_wstate = eefac_pkg::EEFAC_IDLE;
                    next_write_start = 1'b0;
                    next_abort_flag = 1'b0;
                end
            end
            default: next_wcount = 16'h0000;
        endcase

        if (bus_wr)
        begin
            // any write other than the next key breaks the unlock sequence
            next_key_stage = 2'd0;
            unique case (reg_addr)
                `EEFAC_OFS_DATA_LOW: next_data_low = reg_wdata;
                `EEFAC_OFS_DATA_HIGH: next_word_high = reg_wdata[5:0];
                `EEFAC_OFS_ADDR_LOW: next_address_low = reg_wdata;
                `EEFAC_OFS_ADDR_HIGH: next_address_high = reg_wdata[4:0];
                `EEFAC_OFS_CONTROL:
                begin
                    next_memory_select = reg_wdata[`EEFAC_CTL_SEL];
                    next_abort_flag = reg_wdata[`EEFAC_CTL_ABORT];
                    next_write_permit = reg_wdata[`EEFAC_CTL_PERMIT];
                    // permit is taken from before this write, so one write cannot unlock itself
                    if (reg_wdata[`EEFAC_CTL_WSTART] && !reg_wdata[`EEFAC_CTL_SEL] && write_permit
                        && (key_stage == 2'd2) && (wstate == eefac_pkg::EEFAC_IDLE))
                    begin
                        next_write_start = 1'b1;
                        next_wstate = eefac_pkg::EEFAC_ERASE;
                        next_wcount = 16'(`EEFAC_ERASE_CYCLES);
                        next_latch_addr = nv_address_low;
                        next_latch_data = nv_data_low;
                    end
                    if (reg_wdata[`EEFAC_CTL_RSTART] && (pread == eefac_pkg::EEFAC_PR_NONE))
                    begin
                        if (reg_wdata[`EEFAC_CTL_SEL])
                        begin
                            next_read_start = 1'b1;
                            next_pread = eefac_pkg::EEFAC_PR_FIRST;
                        end
                        else
                            next_data_low = rd_byte;
                    end
                end
                `EEFAC_OFS_UNLOCK:
                begin
                    if (reg_wdata == `EEFAC_KEY_FIRST)
                        next_key_stage = 2'd1;
                    else if ((reg_wdata == `EEFAC_KEY_SECOND) && (key_stage == 2'd1))
                        next_key_stage = 2'd2;
                end
                `EEFAC_OFS_STATUS:
                begin
                    if (reg_wdata[`EEFAC_STS_DONE])
                        next_done_flag = 1'b0;
                end
                default: next_key_stage = 2'd0;
            endcase
        end

        // completion wins over a software write in the same cycle
        if (prog_en)
        begin
            next_done_flag = 1'b1;
            next_abort_flag = 1'b0;
        end

        // a device reset ends everything; an unfinished write leaves its mark
        if (dev_rst)
        begin
            next_abort_flag = write_abort_flag || (wstate != eefac_pkg::EEFAC_IDLE);
            next_data_low = `EEFAC_BYTE_ZERO;
            next_word_high = 6'h00;
            next_address_low = `EEFAC_BYTE_ZERO;
            next_address_high = 5'h00;
            next_memory_select = 1'b0;
            next_write_permit = 1'b0;
            next_write_start = 1'b0;
            next_read_start = 1'b0;
            next_done_flag = 1'b0;
            next_key_stage = 2'd0;
            next_wstate = eefac_pkg::EEFAC_IDLE;
            next_pread = eefac_pkg::EEFAC_PR_NONE;
            next_wcount = 16'h0000;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            nv_data_low <= `EEFAC_BYTE_ZERO;
            program_word_high <= 6'h00;
            nv_address_low <= `EEFAC_BYTE_ZERO;
            program_address_high <= 5'h00;
            memory_select <= 1'b0;
            write_abort_flag <= 1'b0;
            write_permit <= 1'b0;
            write_start <= 1'b0;
            read_start <= 1'b0;
            done_flag <= 1'b0;
            key_stage <= 2'd0;
            wstate <= eefac_pkg::EEFAC_IDLE;
            pread <= eefac_pkg::EEFAC_PR_NONE;
            wcount <= 16'h0000;
            latch_addr <= `EEFAC_BYTE_ZERO;
            latch_data <= `EEFAC_BYTE_ZERO;
            reg_rdata <= `EEFAC_BYTE_ZERO;
        end
        else
        begin
            nv_data_low <= next_data_low;
            program_word_high <= next_word_high;
            nv_address_low <= next_address_low;
            program_address_high <= next_address_high;
            memory_select <= next_memory_select;
            write_abort_flag <= next_abort_flag;
            write_permit <= next_write_permit;
            write_start <= next_write_start;
            read_start <= next_read_start;
            done_flag <= next_done_flag;
            key_stage <= next_key_stage;
            wstate <= next_wstate;
            pread <= next_pread;
            wcount <= next_wcount;
            latch_addr <= next_latch_addr;
            latch_data <= next_latch_data;
            reg_rdata <= next_rdata;
        end
    end

    assign prog_addr = {program_address_high, nv_address_low};
    assign write_done_irq_flag = done_flag;
    assign write_busy = write_start;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst || dev_rst);

    sequence s_prog_read_start;
        bus_wr && (reg_addr == `EEFAC_OFS_CONTROL) && reg_wdata[`EEFAC_CTL_RSTART]
            && reg_wdata[`EEFAC_CTL_SEL] && (pread == eefac_pkg::EEFAC_PR_NONE);
    endsequence
    sequence s_ctrl_write_start;
        bus_wr && (reg_addr == `EEFAC_OFS_CONTROL) && reg_wdata[`EEFAC_CTL_WSTART]
            && (wstate == eefac_pkg::EEFAC_IDLE);
    endsequence

    a_word_high_zero: assert property (bus_rd && (reg_addr == `EEFAC_OFS_DATA_HIGH)
        |=> reg_rdata[7:6] == 2'b00 && reg_rdata[5:0] == $past(program_word_high))
        else $error("high data read shows upper bits");
    a_addr_high_zero: assert property (bus_rd && (reg_addr == `EEFAC_OFS_ADDR_HIGH)
        |=> reg_rdata[7:5] == 3'b000)
        else $error("high address read shows upper bits");
    a_ctrl_mid_zero: assert property (bus_rd && (reg_addr == `EEFAC_OFS_CONTROL)
        |=> reg_rdata[6:4] == 3'b000)
        else $error("control middle bits not zero");
    a_unlock_reads_zero: assert property (reg_rd && (reg_addr == `EEFAC_OFS_UNLOCK)
        |=> reg_rdata == 8'h00)
        else $error("unlock port read not zero");
    a_prog_no_write: assert property (s_ctrl_write_start and reg_wdata[`EEFAC_CTL_SEL]
        |=> !write_start && (wstate == eefac_pkg::EEFAC_IDLE))
        else $error("write started with program memory selected");
    a_keys_needed: assert property (s_ctrl_write_start and (key_stage != 2'd2)
        |=> !write_start)
        else $error("write started without unlock keys");
    a_permit_needed: assert property (s_ctrl_write_start and !write_permit
        |=> !write_start)
        else $error("write started without write permit");
    a_data_read_next: assert property (bus_wr && (reg_addr == `EEFAC_OFS_CONTROL)
        && reg_wdata[`EEFAC_CTL_RSTART] && !reg_wdata[`EEFAC_CTL_SEL] && (pread == eefac_pkg::EEFAC_PR_NONE)
        |=> nv_data_low == $past(rd_byte))
        else $error("data byte not loaded after read start");
    a_prog_read_word: assert property (s_prog_read_start
        |=> read_start ##1 read_start ##1 !read_start && nv_data_low == $past(prog_word[7:0])
            && program_word_high == $past(prog_word[13:8]))
        else $error("program word not captured in second cycle");
    a_write_held: assert property ($rose(write_start) |-> write_start [*8])
        else $error("write start dropped early");
    a_write_done: assert property (prog_en |=> !write_start && done_flag && !write_abort_flag)
        else $error("write end not reported");
    a_abort_flag_set: assert property (@(posedge clock) disable iff (sys_rst)
        dev_rst && (wstate != eefac_pkg::EEFAC_IDLE) |=> write_abort_flag
            && nv_address_low == 8'h00 && nv_data_low == 8'h00)
        else $error("aborted write not flagged");
    a_permit_kept: assert property (!(bus_wr && reg_addr == `EEFAC_OFS_CONTROL)
        |=> write_permit == $past(write_permit))
        else $error("write permit changed by hardware");

endmodule

// file: include/eefac_consts.svh
`ifndef EEFAC_CONSTS_SVH
`define EEFAC_CONSTS_SVH

// register indices on the plain register port
`define EEFAC_OFS_DATA_LOW 3'h0
`define EEFAC_OFS_DATA_HIGH 3'h1
`define EEFAC_OFS_ADDR_LOW 3'h2
`define EEFAC_OFS_ADDR_HIGH 3'h3
`define EEFAC_OFS_CONTROL 3'h4
`define EEFAC_OFS_UNLOCK 3'h5
`define EEFAC_OFS_STATUS 3'h6

// control and status register field positions
`define EEFAC_CTL_SEL 7
`define EEFAC_CTL_ABORT 3
`define EEFAC_CTL_PERMIT 2
`define EEFAC_CTL_WSTART 1
`define EEFAC_CTL_RSTART 0
`define EEFAC_STS_DONE 0

// reset values and fixed patterns
`define EEFAC_BYTE_ZERO 8'h00
`define EEFAC_ERASED_BYTE 8'hFF
`define EEFAC_KEY_FIRST 8'h55
`define EEFAC_KEY_SECOND 8'hAA

// self-timed write, least times rounded up to whole cycles
`define EEFAC_CLK_PERIOD_NS 10
`define EEFAC_ERASE_TIME_NS 2000
`define EEFAC_PROG_TIME_NS 2000
`define EEFAC_ERASE_CYCLES ((`EEFAC_ERASE_TIME_NS + `EEFAC_CLK_PERIOD_NS - 1) / `EEFAC_CLK_PERIOD_NS)
`define EEFAC_PROG_CYCLES ((`EEFAC_PROG_TIME_NS + `EEFAC_CLK_PERIOD_NS - 1) / `EEFAC_CLK_PERIOD_NS)

`endif

// file: include/eefac_pkg.sv
package eefac_pkg;

    typedef enum logic [1:0] {
        EEFAC_IDLE = 2'b00,
        EEFAC_ERASE = 2'b01,
        EEFAC_PROGRAM = 2'b11
    } eefac_wstate_t;

    typedef enum logic [1:0] {
        EEFAC_PR_NONE = 2'b00,
        EEFAC_PR_FIRST = 2'b01,
        EEFAC_PR_SECOND = 2'b11
    } eefac_pread_t;

endpackage

// file: tb/tb.sv
`timescale 1ns/100ps
`include "eefac_consts.svh"

module tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] dev_rst = 3'h0;
    logic [12:0] prog_addr;
    logic [13:0] prog_word = 14'h0000;
    logic write_done_irq_flag;
    logic write_busy;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    eefac_ctrl eefac_ctrl_i (
        .clock(clock),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .external_reset_pin(dev_rst[0]),
        .watchdog_reset_source(dev_rst[1]),
        .brownout_reset_source(dev_rst[2]),
        .prog_addr(prog_addr),
        .prog_word(prog_word),
        .write_done_irq_flag(write_done_irq_flag),
        .write_busy(write_busy)
    );

    always #5 clock = ~clock;

    task automatic finish_test();
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // two full writes of 400 cycles, three writes cut short by reset, plus register traffic fit well inside this
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    // a gap cycle follows each strobe so no strobe is assigned twice in one step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, e);
        @(posedge clock);
    endtask

    task automatic busy_is(input logic e);
        #1;
        chk1(write_busy, e);
    endtask

    task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
        wr(`EEFAC_OFS_UNLOCK, k1);
        wr(`EEFAC_OFS_UNLOCK, k2);
    endtask

    task automatic start_write(input logic [7:0] a, input logic [7:0] d);
        wr(`EEFAC_OFS_ADDR_LOW, a);
        wr(`EEFAC_OFS_DATA_LOW, d);
        wr(`EEFAC_OFS_CONTROL, 8'h04);
        keys(8'h55, 8'hAA);
        wr(`EEFAC_OFS_CONTROL, 8'h06);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        #1;
        while (write_busy !== 1'b0 && n < 1000)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        chk1(write_busy, 1'b0);
        @(posedge clock);
    endtask

    task automatic dev_reset(input int s);
        dev_rst[s] <= 1'b1;
        repeat (8) @(posedge clock);
        dev_rst[s] <= 1'b0;
        repeat (8) @(posedge clock);
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rdchk(3'(i), 8'h00);
        wr(`EEFAC_OFS_DATA_HIGH, 8'hFF);
        rdchk(`EEFAC_OFS_DATA_HIGH, 8'h3F);
        wr(`EEFAC_OFS_ADDR_HIGH, 8'hF2);
        rdchk(`EEFAC_OFS_ADDR_HIGH, 8'h12);
        wr(`EEFAC_OFS_ADDR_LOW, 8'h34);
        chk8(prog_addr[7:0], 8'h34);
        chk8({3'h0, prog_addr[12:8]}, 8'h12);
        prog_word <= 14'h2ABC;
        wr(`EEFAC_OFS_CONTROL, 8'h81);
        // this store lands in the ignored cycle and must be dropped
        wr(`EEFAC_OFS_DATA_LOW, 8'h11);
        rdchk(`EEFAC_OFS_DATA_LOW, 8'hBC);
        rdchk(`EEFAC_OFS_DATA_HIGH, 8'h2A);
        rdchk(`EEFAC_OFS_CONTROL, 8'h80);
        wr(`EEFAC_OFS_ADDR_LOW, 8'h00);
        rdchk(`EEFAC_OFS_DATA_LOW, 8'hBC);
        wr(`EEFAC_OFS_CONTROL, 8'h00);
        keys(8'h55, 8'hAA);
        wr(`EEFAC_OFS_CONTROL, 8'h02);
        busy_is(1'b0);
        wr(`EEFAC_OFS_CONTROL, 8'h04);
        keys(8'hAA, 8'h55);
        wr(`EEFAC_OFS_CONTROL, 8'h06);
        busy_is(1'b0);
        keys(8'h55, 8'hAA);
        wr(`EEFAC_OFS_DATA_LOW, 8'h00);
        wr(`EEFAC_OFS_CONTROL, 8'h06);
        busy_is(1'b0);
        wr(`EEFAC_OFS_CONTROL, 8'h84);
        keys(8'h55, 8'hAA);
        wr(`EEFAC_OFS_CONTROL, 8'h86);
        busy_is(1'b0);
        rdchk(`EEFAC_OFS_CONTROL, 8'h84);
        for (int s = 0; s < 3; s++)
        begin
            start_write(8'h20, 8'hC3);
            busy_is(1'b1);
            repeat (50) @(posedge clock);
            dev_reset(s);
            rdchk(`EEFAC_OFS_CONTROL, 8'h08);
            rdchk(`EEFAC_OFS_DATA_LOW, 8'h00);
            rdchk(`EEFAC_OFS_ADDR_LOW, 8'h00);
        end
        start_write(8'h20, 8'h5A);
        busy_is(1'b1);
        wait_idle();
        chk1(write_done_irq_flag, 1'b1);
        rdchk(`EEFAC_OFS_CONTROL, 8'h04);
        rdchk(`EEFAC_OFS_STATUS, 8'h01);
        wr(`EEFAC_OFS_STATUS, 8'h01);
        chk1(write_done_irq_flag, 1'b0);
        wr(`EEFAC_OFS_DATA_LOW, 8'h00);
        wr(`EEFAC_OFS_CONTROL, 8'h05);
        rdchk(`EEFAC_OFS_DATA_LOW, 8'h5A);
        rdchk(`EEFAC_OFS_CONTROL, 8'h04);
        start_write(8'h21, 8'h96);
        rdchk(`EEFAC_OFS_CONTROL, 8'h06);
        // software tries to clear both permit and write start mid-write
        wr(`EEFAC_OFS_CONTROL, 8'h00);
        rdchk(`EEFAC_OFS_CONTROL, 8'h02);
        wait_idle();
        rdchk(`EEFAC_OFS_CONTROL, 8'h00);
        wr(`EEFAC_OFS_CONTROL, 8'h01);
        rdchk(`EEFAC_OFS_DATA_LOW, 8'h96);
        finish_test();
    end
endmodule
